//--- adc_seq_pkg.sv
package adc_seq_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] RESULT_LOW_OFFSET   = 8'h24;
   localparam logic [7:0] RESULT_HIGH_OFFSET  = 8'h25;
   localparam logic [7:0] CONTROL_OFFSET      = 8'h26;
   localparam logic [7:0] CLOCK_SELECT_OFFSET = 8'h27;
   localparam logic [7:0] IRQ_STATUS_OFFSET   = 8'h28;
   localparam logic [7:0] IRQ_MASK_OFFSET     = 8'h29;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CHANNEL_LSB     = 0;
   localparam int PORT_CONFIG_LSB = 3;
   localparam int PENDING_BIT     = 6;
   localparam int START_BIT       = 7;
   localparam int DIVIDER_LSB     = 0;
   localparam int TEST_BIT        = 7;
   localparam int IRQ_DONE_BIT    = 0;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] CONTROL_RESET      = 8'h00;
   localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET          = 8'h00;
   localparam logic [9:0] RESULT_RESET       = 10'h000;

   // ****************************************
   // timing
   // ****************************************
   localparam logic [6:0] CONVERSION_TICKS = 7'h4c;
   localparam logic [6:0] SAMPLE_TICKS     = 7'h20;
   localparam logic [4:0] DIV2_MASK        = 5'h01;
   localparam logic [4:0] DIV8_MASK        = 5'h07;
   localparam logic [4:0] DIV32_MASK       = 5'h1f;

   typedef enum logic [1:0] {
      DIV_2   = 2'h0,
      DIV_8   = 2'h1,
      DIV_32  = 2'h2,
      DIV_UND = 2'h3
   } clock_divider_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_ARMED  = 2'h1,
      ST_SAMPLE = 2'h3,
      ST_CONV   = 2'h2
   } conv_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] analog_enable;
      logic [2:0] channel;
      logic       powered;
      logic       sampling;
   } analog_ctrl_t;

endpackage

//--- adc_sequencer_control.sv
// Summary of operation
// RULE1 - the ten-bit result keeps bits 9..2 in the high byte and bits 1..0 in bits 7..6 of the low byte.
// RULE2 - both result bytes are read-only and writes leave the stored result unchanged.
// RULE3 - control bits 2..0 select which of the eight analog inputs feeds the converter.
// RULE4 - control bits 5..3 with value N make the lowest N port lines analog, value 7 makes all eight analog.
// RULE5 - an analog port line loses its digital function and pull-high and the converter is powered.
// RULE6 - a zero port configuration powers the converter down and leaves all port lines digital.
// RULE7 - a rising start bit resets the converter and sets the pending flag to one.
// RULE8 - a falling start bit after a rise begins a conversion on the selected channel.
// RULE9 - completion clears the pending flag and sets the interrupt request flag, gated by its mask.
// RULE10 - software holds start low after a pulse until the pending flag reads zero.
// RULE11 - software pulses start within ten instruction cycles after setting a nonzero port configuration.
// RULE12 - clock select bits 1..0 give system clock divided by 2, 8 or 32, code 3 undefined.
// RULE13 - clock select bits 2..6 read as zero.
// RULE14 - software leaves clock select bit 7 alone, it is for factory test only.
// RULE15 - a conversion lasts 76 converter clocks, the first 32 of them sampling.
// RULE16 - the converter clock is an enable from a free-running divider and both result bytes load together at completion.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control (
   input  wire logic                         clk_sys,
   input  wire logic                         sys_rst,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [7:0]                        reg_rdata,
   input  wire logic [9:0]                   sar_result,
   output adc_seq_pkg::analog_ctrl_t         analog_ctrl,
   output logic [7:0]                        port_digital_disable,
   output logic                              irq
);

   // ****************************************
   // register bus
   // ****************************************
   adc_seq_pkg::reg_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   logic [2:0] channel_reg, channel_next;
   logic [2:0] port_cfg_reg, port_cfg_next;
   logic       start_reg, start_next;
   logic       pending_reg, pending_next;
   logic [1:0] divsel_reg, divsel_next;
   logic       test_reg, test_next;
   logic       irq_status_reg, irq_status_next;
   logic       irq_mask_reg, irq_mask_next;
   logic [9:0] result_reg, result_next;
   logic [7:0] rdata_reg, rdata_next;

   // ****************************************
   // converter clock divider
   // ****************************************
   logic [4:0] div_cnt_reg, div_cnt_next;
   logic       tick;

   function automatic logic [4:0] div_mask(input logic [1:0] sel);
      case (sel)
         adc_seq_pkg::DIV_2:  div_mask = adc_seq_pkg::DIV2_MASK;
         adc_seq_pkg::DIV_8:  div_mask = adc_seq_pkg::DIV8_MASK;
         adc_seq_pkg::DIV_32: div_mask = adc_seq_pkg::DIV32_MASK;
         // undefined code: slowest rate, a safe choice
         default:             div_mask = adc_seq_pkg::DIV32_MASK;
      endcase
   endfunction

   always_comb begin
      div_cnt_next = div_cnt_reg + 5'h01;                             // [RULE16]
   end
   assign tick = ((div_cnt_reg & div_mask(divsel_reg)) == div_mask(divsel_reg)); // [RULE12]

   // ****************************************
   // conversion sequencer
   // ****************************************
   adc_seq_pkg::conv_state_t state_reg, state_next;
   logic [6:0] tick_cnt_reg, tick_cnt_next;
   logic       start_rise, start_fall, done;

   // ****************************************
   // start edge detector
   // ****************************************
   always_comb begin
      start_next = start_reg;
      if (req.wr && req.addr == adc_seq_pkg::CONTROL_OFFSET) begin
         start_next = req.wdata[adc_seq_pkg::START_BIT];
      end
   end
   assign start_rise = !start_reg && start_next;
   assign start_fall = start_reg && !start_next;

   always_comb begin
      state_next    = state_reg;
      tick_cnt_next = tick_cnt_reg;
      done          = 1'b0;
      case (state_reg)
         adc_seq_pkg::ST_IDLE: begin
            if (start_rise) begin
               state_next = adc_seq_pkg::ST_ARMED;                    // [RULE7]
            end
         end
         adc_seq_pkg::ST_ARMED: begin
            // count held at zero until the falling write starts sampling
            tick_cnt_next = 7'h00;
            if (start_fall) begin
               state_next = adc_seq_pkg::ST_SAMPLE;                   // [RULE8]
            end
         end
         adc_seq_pkg::ST_SAMPLE, adc_seq_pkg::ST_CONV: begin
            if (tick) begin
               tick_cnt_next = tick_cnt_reg + 7'h01;
               if (tick_cnt_next == adc_seq_pkg::SAMPLE_TICKS) begin
                  state_next = adc_seq_pkg::ST_CONV;                  // [RULE15]
               end
               if (tick_cnt_next == adc_seq_pkg::CONVERSION_TICKS) begin
                  state_next = adc_seq_pkg::ST_IDLE;                  // [RULE15]
                  done       = 1'b1;
               end
            end
         end
         default: state_next = adc_seq_pkg::ST_IDLE;
      endcase
      // a new rising start aborts and rearms, whatever is in flight
      if (start_rise) begin
         state_next    = adc_seq_pkg::ST_ARMED;                       // [RULE7]
         tick_cnt_next = 7'h00;
         done          = 1'b0;
      end
   end

   // ****************************************
   // registers next values
   // ****************************************
   always_comb begin
      channel_next    = channel_reg;
      port_cfg_next   = port_cfg_reg;
      pending_next    = pending_reg;
      divsel_next     = divsel_reg;
      test_next       = test_reg;
      irq_status_next = irq_status_reg;
      irq_mask_next   = irq_mask_reg;
      result_next     = result_reg;
      if (req.wr) begin
         case (req.addr)
            adc_seq_pkg::CONTROL_OFFSET: begin
               channel_next  = req.wdata[adc_seq_pkg::CHANNEL_LSB +: 3];       // [RULE3]
               port_cfg_next = req.wdata[adc_seq_pkg::PORT_CONFIG_LSB +: 3];   // [RULE4]
            end
            adc_seq_pkg::CLOCK_SELECT_OFFSET: begin
               divsel_next = req.wdata[adc_seq_pkg::DIVIDER_LSB +: 2];         // [RULE12]
               // test bit is only stored, it steers nothing
               test_next   = req.wdata[adc_seq_pkg::TEST_BIT];
            end
            adc_seq_pkg::IRQ_STATUS_OFFSET: begin
               if (req.wdata[adc_seq_pkg::IRQ_DONE_BIT]) begin
                  irq_status_next = 1'b0;
               end
            end
            adc_seq_pkg::IRQ_MASK_OFFSET: begin
               irq_mask_next = req.wdata[adc_seq_pkg::IRQ_DONE_BIT];
            end
            // result bytes and unmapped addresses ignore writes
            default: ;                                                        // [RULE2]
         endcase
      end
      if (start_rise) begin
         pending_next = 1'b1;                                                 // [RULE7]
      end
      // after the clear above, so completion beats a same-cycle clear
      if (done) begin
         pending_next    = 1'b0;                                              // [RULE9]
         irq_status_next = 1'b1;                                              // [RULE9]
         result_next     = sar_result;                                        // [RULE16]
      end
   end

   // ****************************************
   // read data
   // ****************************************
   always_comb begin
      rdata_next = 8'h00;
      if (req.rd) begin
         case (req.addr)
            adc_seq_pkg::RESULT_LOW_OFFSET:   rdata_next = {result_reg[1:0], 6'h00};        // [RULE1]
            adc_seq_pkg::RESULT_HIGH_OFFSET:  rdata_next = result_reg[9:2];                 // [RULE1]
            adc_seq_pkg::CONTROL_OFFSET:
               rdata_next = {start_reg, pending_reg, port_cfg_reg, channel_reg};
            adc_seq_pkg::CLOCK_SELECT_OFFSET: rdata_next = {test_reg, 5'h00, divsel_reg};   // [RULE13]
            adc_seq_pkg::IRQ_STATUS_OFFSET:   rdata_next = {7'h00, irq_status_reg};
            adc_seq_pkg::IRQ_MASK_OFFSET:     rdata_next = {7'h00, irq_mask_reg};
            default:                          rdata_next = 8'h00;
         endcase
      end
   end

   // ****************************************
   // divider and sequencer registers
   // ****************************************
   // free-running, so a start never waits for a divider restart
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         div_cnt_reg <= 5'h00;
      end else begin
         div_cnt_reg <= div_cnt_next;                                         // [RULE16]
      end
   end

   // edge detector and sequencer share one register group
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         start_reg    <= adc_seq_pkg::CONTROL_RESET[7];
         state_reg    <= adc_seq_pkg::ST_IDLE;
         tick_cnt_reg <= 7'h00;
      end else begin
         start_reg    <= start_next;
         state_reg    <= state_next;
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // ****************************************
   // control and status registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         channel_reg    <= adc_seq_pkg::CONTROL_RESET[2:0];
         port_cfg_reg   <= adc_seq_pkg::CONTROL_RESET[5:3];
         pending_reg    <= adc_seq_pkg::CONTROL_RESET[6];
         divsel_reg     <= adc_seq_pkg::CLOCK_SELECT_RESET[1:0];
         test_reg       <= adc_seq_pkg::CLOCK_SELECT_RESET[7];
         irq_status_reg <= adc_seq_pkg::IRQ_RESET[0];
         irq_mask_reg   <= adc_seq_pkg::IRQ_RESET[0];
         result_reg     <= adc_seq_pkg::RESULT_RESET;
      end else begin
         channel_reg    <= channel_next;
         port_cfg_reg   <= port_cfg_next;
         pending_reg    <= pending_next;
         divsel_reg     <= divsel_next;
         test_reg       <= test_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg   <= irq_mask_next;
         result_reg     <= result_next;
      end
   end

   // ****************************************
   // read data register
   // ****************************************
   // read data stands for one cycle only, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************
   // analog side and outputs
   // ****************************************
   logic [7:0] lines_reg, lines_next;
   logic       powered_reg, powered_next;
   logic       sampling_reg, sampling_next;
   logic       irq_reg, irq_next;

   // decoded from next values, so outputs flip on the same edge as the registers
   always_comb begin
      lines_next = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (port_cfg_next == 3'h7 || i < int'(port_cfg_next)) begin
            lines_next[i] = 1'b1;                                             // [RULE4]
         end
      end
      powered_next  = (port_cfg_next != 3'h0);                                // [RULE5] [RULE6]
      sampling_next = (state_next == adc_seq_pkg::ST_SAMPLE);                 // [RULE15]
      irq_next      = irq_status_next && irq_mask_next;                       // [RULE9]
   end

   // ****************************************
   // output registers
   // ****************************************
   // data outputs straight from flops, no decode glitches on the pins
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         lines_reg    <= 8'h00;
         powered_reg  <= 1'b0;
         sampling_reg <= 1'b0;
         irq_reg      <= 1'b0;
      end else begin
         lines_reg    <= lines_next;
         powered_reg  <= powered_next;
         sampling_reg <= sampling_next;
         irq_reg      <= irq_next;
      end
   end

   assign analog_ctrl.analog_enable = lines_reg;
   assign analog_ctrl.channel       = channel_reg;                            // [RULE3]
   assign analog_ctrl.powered       = powered_reg;                            // [RULE5] [RULE6]
   assign analog_ctrl.sampling      = sampling_reg;                           // [RULE15]
   assign port_digital_disable      = lines_reg;                              // [RULE5]
   assign reg_rdata                 = rdata_reg;
   assign irq                       = irq_reg;                                // [RULE9]

endmodule
`default_nettype wire

//--- adc_sar_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_sar_model (
   input  wire logic                      clk_sys,
   input  wire adc_seq_pkg::analog_ctrl_t analog_ctrl,
   output logic [9:0]                     sar_result
);
   // ****************************************
   // far-side converter stand-in
   // ****************************************
   initial sar_result = 10'h155;
   // unpowered front end holds nothing stable, so the value churns
   always @(posedge clk_sys) begin
      if (analog_ctrl.powered) begin
         sar_result <= {{3{analog_ctrl.channel}}, 1'b1};
      end else begin
         sar_result <= ~sar_result;
      end
   end
endmodule
`default_nettype wire

//--- adc_seq_chk.sv
`timescale 1ns/1ns
`default_nettype none
module adc_seq_chk (
   input wire logic                      clk_sys,
   input wire logic                      sys_rst,
   input wire logic [7:0]                reg_addr,
   input wire logic [7:0]                reg_wdata,
   input wire logic                      reg_wr,
   input wire logic                      reg_rd,
   input wire logic [7:0]                reg_rdata,
   input wire adc_seq_pkg::analog_ctrl_t analog_ctrl,
   input wire logic [7:0]                port_digital_disable,
   input wire logic                      irq
);
   // ****************************************
   // helpers and properties
   // ****************************************
   logic        ctl_wr, rise, start_reg, start_next;
   logic [7:0]  lines_exp;
   logic [10:0] samp_reg, samp_next;
   always_comb begin
      ctl_wr     = reg_wr && reg_addr == adc_seq_pkg::CONTROL_OFFSET;
      rise       = ctl_wr && reg_wdata[7] && !start_reg;
      start_next = ctl_wr ? reg_wdata[7] : start_reg;
      lines_exp  = (reg_wdata[5:3] == 3'h7) ? 8'hff : 8'hff >> (4'h8 - {1'b0, reg_wdata[5:3]});
      samp_next  = analog_ctrl.sampling ? samp_reg + 11'h001 : 11'h000;
   end
   always_ff @(posedge clk_sys) begin
      start_reg <= sys_rst ? 1'b0 : start_next;
      samp_reg  <= sys_rst ? 11'h000 : samp_next;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_port_disable: assert property (ctl_wr |=> port_digital_disable == $past(lines_exp))
      else $error("digital disable does not follow port config write");
   a_power_cfg: assert property (analog_ctrl.powered == (analog_ctrl.analog_enable != 8'h00))
      else $error("power state does not follow port config");
   a_enable_shape: assert property (((analog_ctrl.analog_enable + 8'h01) & analog_ctrl.analog_enable) == 8'h00
      && analog_ctrl.analog_enable != 8'h7f)
      else $error("analog enable not a legal low-lines pattern");
   a_chan_write: assert property (ctl_wr |=> analog_ctrl.channel == $past(reg_wdata[2:0]))
      else $error("channel does not follow control write");
   a_cfg_all: assert property (ctl_wr && reg_wdata[5:3] == 3'h7 |=> analog_ctrl.analog_enable == 8'hff)
      else $error("config 7 did not make all lines analog");
   a_cfg_zero: assert property (ctl_wr && reg_wdata[5:3] == 3'h0 |=> !analog_ctrl.powered)
      else $error("config 0 left converter powered");
   a_unused_zero: assert property (reg_rd && reg_addr == adc_seq_pkg::CLOCK_SELECT_OFFSET
      |=> reg_rdata[6:2] == 5'h00)
      else $error("unused clock select bits read nonzero");
   a_rise_pending: assert property (rise ##2 (reg_rd && reg_addr == adc_seq_pkg::CONTROL_OFFSET)
      |=> reg_rdata[6])
      else $error("pending flag not set after start rise");
   a_rise_abort: assert property (rise |=> !analog_ctrl.sampling)
      else $error("start rise did not reset the converter");
   a_sample_bound: assert property (samp_reg <= 11'h400)
      else $error("sampling phase too long");
   a_irq_mask: assert property (reg_wr && reg_addr == adc_seq_pkg::IRQ_MASK_OFFSET && !reg_wdata[0]
      |=> !irq)
      else $error("masked interrupt still high");
endmodule
bind adc_sequencer_control adc_seq_chk i_adc_seq_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_ctrl(analog_ctrl),
   .port_digital_disable(port_digital_disable), .irq(irq));
`default_nettype wire

//--- adc_sequencer_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control_tb;
   // ****************************************
   // bench
   // ****************************************
   logic                      clk_sys, sys_rst, reg_wr, reg_rd, irq;
   logic [7:0]                reg_addr, reg_wdata, reg_rdata, port_digital_disable, r;
   logic [9:0]                sar_result;
   adc_seq_pkg::analog_ctrl_t analog_ctrl;
   int                        n_fail, compares, n;
   adc_sequencer_control i_adc_sequencer_control (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sar_result(sar_result),
      .analog_ctrl(analog_ctrl), .port_digital_disable(port_digital_disable), .irq(irq));
   adc_sar_model i_adc_sar_model (.clk_sys(clk_sys), .analog_ctrl(analog_ctrl), .sar_result(sar_result));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one conversion: divider code, channel, irq mask, abort by a second rise
   task automatic conv(input logic [1:0] div, input logic [2:0] ch, input logic msk, input logic abort);
      logic [9:0] v;
      int         d;
      d = (div == 2'h0) ? 2 : (div == 2'h1) ? 8 : 32;
      v = {ch, ch, ch, 1'b1};
      wr(8'h27, {6'h00, div});
      wr(8'h29, {7'h00, msk});
      wr(8'h26, {2'b10, 3'h7, ch});
      if (abort) begin
         wr(8'h26, {2'b00, 3'h7, ch});
         repeat (20) @(posedge clk_sys);
         wr(8'h26, {2'b10, 3'h7, ch});
      end
      rd(8'h26, r);
      chk(r[6], 1'b1);
      wr(8'h26, {2'b00, 3'h7, ch});
      n = 0;
      // start stays low while polling
      do begin
         rd(8'h26, r);
         n += 2;
      end while (r[6] && n < 3000);
      chk(n >= 75 * d && n <= 76 * d + 4, 1'b1);
      chk(irq, msk);
      rd(8'h28, r);
      chk(r[0], 1'b1);
      wr(8'h25, 8'hff);
      wr(8'h24, 8'hff);
      rd(8'h25, r);
      chk(r, v[9:2]);
      rd(8'h24, r);
      chk(r, {v[1:0], 6'h00});
      wr(8'h28, 8'h01);
      rd(8'h28, r);
      chk(r[0], 1'b0);
      chk(irq, 1'b0);
      $display("conversion test div %0d done", d);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, n_fail, compares} = '0;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(8'h24, r);
      chk(r, 8'h00);
      wr(8'h27, 8'h7f);
      rd(8'h27, r);
      chk(r, 8'h03);
      rd(8'h30, r);
      chk(r, 8'h00);
      $display("register test done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h26, {2'b00, c[2:0], c[2:0]});
         rd(8'h26, r);
         chk(r[5:0], {c[2:0], c[2:0]});
         chk(port_digital_disable, (c == 7) ? 8'hff : 8'((1 << c) - 1));
         chk(analog_ctrl.powered, c != 0);
         chk(analog_ctrl.channel, c[2:0]);
      end
      $display("port config test done");
      conv(2'h0, 3'h5, 1'b1, 1'b1);
      conv(2'h1, 3'h2, 1'b1, 1'b0);
      conv(2'h2, 3'h7, 1'b0, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
